// ---- include/tmw_defs.svh ----
// Purpose: Constants for the 8-bit waveform timer (register map, fields, resets).
// Assumes: APB word addressing, 32-bit data, registers in the low byte.
// Notes: Notes on behaviour follow.
// Notes on behaviour
// - Force strobe acts only in normal or clear-on-compare mode.
// - Force strobe makes an immediate match; output follows compare mode field.
// - Forced match sets no compare flag and never clears the counter.
// - Force strobe is not stored and reads back as zero.
// - Mode field in control bits 6 and 3 picks count, top, waveform.
// - Top is 0xff except compare value in mode 2; buffered compare in PWM.
// - Nonzero compare mode takes the pin; driver still needs direction bit.
// - Non-PWM: 0 off, 1 toggle, 2 clear, 3 set on match.
// - Fast PWM: 2 clear on match set at top; 3 the reverse.
// - Phase correct: 2 clear on up match, set on down match; 3 reverse.
// - PWM with compare equal top and upper bit set: act at top.
// - Clock select: 0 stops, 1..7 divide by 1,8,32,64,128,256,1024.
// - Counter register readable and writable at any time.
// - Counter write blocks the compare match on the next timer clock.
// - Compare register continuously compared; match sets flag or drives pin.
// - Timer clock is a clock enable qualifying the system clock.
// - Clear-on-compare counts up to compare then clears; wraps if below.
// - Phase correct counts up to max, holds one clock, then down.
// - Fast PWM counts to max then clears on the next timer clock.
`ifndef TMW_DEFS_SVH
`define TMW_DEFS_SVH
`define TMW_ADDR_CONTROL 12'h000
`define TMW_ADDR_COUNTER 12'h004
`define TMW_ADDR_COMPARE 12'h008
`define TMW_ADDR_FLAGS 12'h00c
`define TMW_ADDR_PIN_DIR 12'h010
`define TMW_BIT_FORCE 7
`define TMW_BIT_WGM0 6
`define TMW_BIT_COM1 5
`define TMW_BIT_COM0 4
`define TMW_BIT_WGM1 3
`define TMW_BIT_FLAG_CMP 1
`define TMW_BIT_FLAG_OVF 0
`define TMW_CONTROL_RESET 8'h00
`define TMW_COUNTER_RESET 8'h00
`define TMW_COMPARE_RESET 8'h00
`define TMW_MAX 8'hff
`define TMW_BOTTOM 8'h00
`define TMW_PRE_WIDTH 10
`endif

// ---- include/tmw_pkg.sv ----
// Purpose: Types for the 8-bit waveform timer.
// Assumes: tmw_defs.svh holds the numeric constants.
// Notes: Mode encodings follow the two-bit mode field value.
package tmw_pkg;
    typedef enum logic [1:0] {
        TMW_NORMAL,
        TMW_PHASE_PWM,
        TMW_CTC,
        TMW_FAST_PWM
    } tmw_mode_e;
    typedef struct packed {
        logic [1:0] compare_out_mode;
        logic [2:0] clock_sel;
    } tmw_ctrl_s;
endpackage

// ---- rtl/tmw_timer.sv ----
// Purpose: 8-bit timer with compare unit, four waveform modes and APB registers.
// Assumes: Single 100 MHz clock; prescaler source is clk itself (synchronous mode).
// Notes: Flags register is write-one-to-clear; set beats clear.
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/10ps
`include "tmw_defs.svh"
module tmw_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic compare_output_pin,
    output logic compare_output_oe,
    output logic compare_output_override
);
    tmw_pkg::tmw_mode_e wave_mode_sel;
    tmw_pkg::tmw_ctrl_s ctrl;
    logic [7:0] counter_value;
    logic [7:0] compare_value;
    logic [7:0] compare_buf;
    logic pin_dir;
    logic compare_flag;
    logic overflow_flag;
    logic wave_out;
    logic count_down;
    logic block_match;
    logic cmp_pending;
    logic ovf_pending;
    logic [`TMW_PRE_WIDTH-1:0] pre_cnt;
    logic timer_clock_enable;
    logic [`TMW_PRE_WIDTH-1:0] pre_mask;
    logic [7:0] top;
    logic at_top;
    logic is_pwm;
    logic match;
    logic special_top;
    logic wr_en;
    logic rd_en;
    logic wr_ctrl;
    logic wr_cnt;
    logic force_strobe;
    logic [7:0] next_count;
    logic next_down;
    logic next_wave;
    logic ovf_event;
    logic [7:0] control_read;

    // APB decode; every access completes with zero wait states
    assign wr_en = psel && penable && pwrite && pstrb[0];
    assign rd_en = psel && !penable && !pwrite;
    assign wr_ctrl = wr_en && (paddr == `TMW_ADDR_CONTROL);
    assign wr_cnt = wr_en && (paddr == `TMW_ADDR_COUNTER);
    assign is_pwm = (wave_mode_sel == tmw_pkg::TMW_PHASE_PWM) || (wave_mode_sel == tmw_pkg::TMW_FAST_PWM);
    // Strobe is honoured only when the mode being written is not PWM; both PWM
    // modes have the low mode bit set, so that bit alone decides
    assign force_strobe = wr_ctrl && pwdata[`TMW_BIT_FORCE] && !pwdata[`TMW_BIT_WGM0];
    // Strobe bit reads as zero: it is never stored
    assign control_read = {1'b0, wave_mode_sel[0], ctrl.compare_out_mode,
                           wave_mode_sel[1], ctrl.clock_sel};

    // Prescaler tap: one-cycle enable every N clocks
    always_comb begin
        case (ctrl.clock_sel)
            3'h1: pre_mask = 10'h000;
            3'h2: pre_mask = 10'h007;
            3'h3: pre_mask = 10'h01f;
            3'h4: pre_mask = 10'h03f;
            3'h5: pre_mask = 10'h07f;
            3'h6: pre_mask = 10'h0ff;
            3'h7: pre_mask = 10'h3ff;
            default: pre_mask = 10'h000;
        endcase
    end
    // Free-running prescaler shared by all taps, so a tap change does not reset phase
    always_ff @(posedge clk) begin
        if (rst) begin
            pre_cnt <= '0;
        end else begin
            pre_cnt <= pre_cnt + 10'h001;
        end
    end
    assign timer_clock_enable = (ctrl.clock_sel != 3'h0) && ((pre_cnt & pre_mask) == pre_mask);

    // TOP source and compare conditions
    assign top = (wave_mode_sel == tmw_pkg::TMW_CTC) ? compare_value : `TMW_MAX;
    assign at_top = (counter_value == top);
    assign match = (counter_value == compare_value) && !block_match;
    assign special_top = is_pwm && ctrl.compare_out_mode[1] && (compare_value == `TMW_MAX);

    // Count sequence per mode
    always_comb begin
        next_count = counter_value + 8'h01;
        next_down = count_down;
        ovf_event = 1'b0;
        case (wave_mode_sel)
            tmw_pkg::TMW_NORMAL: begin
                ovf_event = (counter_value == `TMW_MAX);
            end
            tmw_pkg::TMW_CTC: begin
                // Counter above compare wraps through max before matching;
                // a counter write suppresses this clear like any other match
                if (at_top && !block_match) begin
                    next_count = `TMW_BOTTOM;
                end
                ovf_event = (counter_value == `TMW_MAX);
            end
            tmw_pkg::TMW_FAST_PWM: begin
                ovf_event = (counter_value == `TMW_MAX);
            end
            tmw_pkg::TMW_PHASE_PWM: begin
                // Holds max for one timer clock by turning there
                if (count_down) begin
                    next_count = counter_value - 8'h01;
                    if (counter_value == `TMW_BOTTOM) begin
                        next_count = counter_value + 8'h01;
                        next_down = 1'b0;
                    end
                end else if (counter_value == `TMW_MAX) begin
                    next_count = counter_value - 8'h01;
                    next_down = 1'b1;
                end
                if (counter_value == `TMW_MAX) begin
                    next_count = `TMW_MAX - 8'h01;
                end
                ovf_event = (counter_value == `TMW_BOTTOM) && count_down;
            end
            default: begin
                next_count = counter_value + 8'h01;
            end
        endcase
    end

    // Counter, direction and match blocking
    always_ff @(posedge clk) begin
        if (rst) begin
            counter_value <= `TMW_COUNTER_RESET;
            count_down <= 1'b0;
            block_match <= 1'b0;
        end else if (wr_cnt) begin
            counter_value <= pwdata[7:0];
            block_match <= 1'b1;
        end else if (timer_clock_enable) begin
            counter_value <= next_count;
            count_down <= next_down;
            block_match <= 1'b0;
        end
    end

    // Compare register: software view and the active copy, buffered at top in PWM
    always_ff @(posedge clk) begin
        if (rst) begin
            compare_buf <= `TMW_COMPARE_RESET;
            compare_value <= `TMW_COMPARE_RESET;
        end else begin
            if (wr_en && (paddr == `TMW_ADDR_COMPARE)) begin
                compare_buf <= pwdata[7:0];
            end
            if (!is_pwm) begin
                compare_value <= (wr_en && (paddr == `TMW_ADDR_COMPARE)) ? pwdata[7:0] : compare_buf;
            end else if (timer_clock_enable && (counter_value == `TMW_MAX)) begin
                compare_value <= compare_buf;
            end
        end
    end

    // Waveform generator; PWM actions decided on the timer clock
    always_comb begin
        next_wave = wave_out;
        if (force_strobe) begin
            // The compare mode written together with the strobe decides its effect
            case (pwdata[`TMW_BIT_COM1:`TMW_BIT_COM0])
                2'h1: next_wave = !wave_out;
                2'h2: next_wave = 1'b0;
                2'h3: next_wave = 1'b1;
                default: next_wave = wave_out;
            endcase
        end else if (timer_clock_enable) begin
            case (wave_mode_sel)
                tmw_pkg::TMW_FAST_PWM: begin
                    if (special_top) begin
                        if (counter_value == `TMW_MAX) begin
                            next_wave = !ctrl.compare_out_mode[0];
                        end
                    end else if (ctrl.compare_out_mode[1] && match) begin
                        next_wave = ctrl.compare_out_mode[0];
                    end else if (ctrl.compare_out_mode[1] && counter_value == `TMW_MAX) begin
                        next_wave = !ctrl.compare_out_mode[0];
                    end
                end
                tmw_pkg::TMW_PHASE_PWM: begin
                    if (special_top) begin
                        if (counter_value == `TMW_MAX) begin
                            next_wave = !ctrl.compare_out_mode[0];
                        end
                    end else if (ctrl.compare_out_mode[1] && match) begin
                        next_wave = count_down ? !ctrl.compare_out_mode[0] : ctrl.compare_out_mode[0];
                    end
                end
                default: begin
                    if (match) begin
                        case (ctrl.compare_out_mode)
                            2'h1: next_wave = !wave_out;
                            2'h2: next_wave = 1'b0;
                            2'h3: next_wave = 1'b1;
                            default: next_wave = wave_out;
                        endcase
                    end
                end
            endcase
        end
    end

    // Output latch and pin drive; override and enable come from flops
    always_ff @(posedge clk) begin
        if (rst) begin
            wave_out <= 1'b0;
            compare_output_pin <= 1'b0;
            compare_output_oe <= 1'b0;
            compare_output_override <= 1'b0;
        end else begin
            wave_out <= next_wave;
            compare_output_pin <= next_wave;
            compare_output_override <= (ctrl.compare_out_mode != 2'h0);
            compare_output_oe <= (ctrl.compare_out_mode != 2'h0) && pin_dir;
        end
    end

    // Control register; strobe bit is consumed, never held
    always_ff @(posedge clk) begin
        if (rst) begin
            wave_mode_sel <= tmw_pkg::TMW_NORMAL;
            ctrl <= '0;
            pin_dir <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                wave_mode_sel <= tmw_pkg::tmw_mode_e'({pwdata[`TMW_BIT_WGM1], pwdata[`TMW_BIT_WGM0]});
                ctrl.compare_out_mode <= pwdata[`TMW_BIT_COM1:`TMW_BIT_COM0];
                ctrl.clock_sel <= pwdata[2:0];
            end
            if (wr_en && (paddr == `TMW_ADDR_PIN_DIR)) begin
                pin_dir <= pwdata[0];
            end
        end
    end

    // Flags: raised one enabled cycle after the condition; forced match never counts
    always_ff @(posedge clk) begin
        if (rst) begin
            cmp_pending <= 1'b0;
            ovf_pending <= 1'b0;
            compare_flag <= 1'b0;
            overflow_flag <= 1'b0;
        end else begin
            if (timer_clock_enable) begin
                cmp_pending <= match;
                ovf_pending <= ovf_event;
            end
            if (timer_clock_enable && cmp_pending) begin
                compare_flag <= 1'b1;
            end else if (wr_en && (paddr == `TMW_ADDR_FLAGS) && pwdata[`TMW_BIT_FLAG_CMP]) begin
                compare_flag <= 1'b0;
            end
            if (timer_clock_enable && ovf_pending) begin
                overflow_flag <= 1'b1;
            end else if (wr_en && (paddr == `TMW_ADDR_FLAGS) && pwdata[`TMW_BIT_FLAG_OVF]) begin
                overflow_flag <= 1'b0;
            end
        end
    end

    // APB read data captured in setup, ready in access; unmapped reads zero with error
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !(paddr == `TMW_ADDR_CONTROL || paddr == `TMW_ADDR_COUNTER ||
                       paddr == `TMW_ADDR_COMPARE || paddr == `TMW_ADDR_FLAGS || paddr == `TMW_ADDR_PIN_DIR);
            if (rd_en) begin
                case (paddr)
                    `TMW_ADDR_CONTROL: prdata <= {24'h000000, control_read};
                    `TMW_ADDR_COUNTER: prdata <= {24'h000000, counter_value};
                    `TMW_ADDR_COMPARE: prdata <= {24'h000000, compare_buf};
                    `TMW_ADDR_FLAGS: prdata <= {30'h00000000, compare_flag, overflow_flag};
                    `TMW_ADDR_PIN_DIR: prdata <= {31'h00000000, pin_dir};
                    default: prdata <= 32'h0000_0000;
                endcase
            end else if (psel && !penable) begin
                // Writes answer with zero data, so no stale read value stands beside pready
                prdata <= 32'h0000_0000;
            end
        end
    end
endmodule

// ---- tb/tmw_timer_checker.sv ----
// Purpose: Port-level assertions for the waveform timer.
// Assumes: Zero-wait APB slave with the byte map of tmw_defs.svh.
// Notes: Compare mode and clock select are shadowed from control writes.
`timescale 1ns/10ps
`include "tmw_defs.svh"
module tmw_timer_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic compare_output_pin,
    input wire logic compare_output_oe,
    input wire logic compare_output_override
);
    logic [1:0] com_w;
    logic [2:0] cs_w;
    logic wr_ctl;
    // A control write lands at the edge where pready is seen
    assign wr_ctl = psel && penable && pready && pwrite && pstrb[0] && paddr == `TMW_ADDR_CONTROL;
    // Shadow of the fields the pin logic depends on
    always_ff @(posedge clk) begin
        if (rst) begin
            com_w <= 2'h0;
            cs_w <= 3'h0;
        end else if (wr_ctl) begin
            com_w <= pwdata[5:4];
            cs_w <= pwdata[2:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    a_ready_first: assert property (s_setup ##1 s_access |-> pready)
        else $error("ready missing in first access cycle");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside an access phase");
    a_unmapped_err: assert property (pready && paddr > `TMW_ADDR_PIN_DIR |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_force_reads_zero: assert property (pready && !pwrite && paddr == `TMW_ADDR_CONTROL |-> prdata[31:7] == 25'h0)
        else $error("control read shows force strobe");
    a_override_mode: assert property (wr_ctl |-> ##[1:2] (compare_output_override == (com_w != 2'h0)))
        else $error("override does not follow compare mode");
    a_oe_needs_mode: assert property (compare_output_oe |-> compare_output_override)
        else $error("driver enabled while disconnected");
    a_stopped_pin: assert property (cs_w == 3'h0 && !$past(wr_ctl) && !$past(wr_ctl, 2) && !$past(wr_ctl, 3)
        |-> $stable(compare_output_pin))
        else $error("pin moved while timer stopped");
endmodule
bind tmw_timer tmw_timer_checker chk_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compare_output_pin(compare_output_pin), .compare_output_oe(compare_output_oe),
    .compare_output_override(compare_output_override));

// ---- tb/test_tmw_timer.sv ----
// Purpose: Self-checking bench for the waveform timer.
// Assumes: Zero-wait APB slave; timer clock taken from clk.
// Notes: Duty windows allow for the pin register lag and count phase.
`timescale 1ns/10ps
`include "tmw_defs.svh"
module test_tmw_timer;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, rerr, pin, oe, ovr;
    int errors = 0, num_checks = 0;
    int divs [7] = '{1, 8, 32, 64, 128, 256, 1024};
    tmw_timer dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .compare_output_pin(pin), .compare_output_oe(oe), .compare_output_override(ovr));
    // Free running clock
    initial begin
        forever #5 clk = ~clk;
    end
    task end_of_test;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; request held until pready is sampled high
    task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            end_of_test();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task t_regs;
        for (int i = 0; i < 5; i++) begin
            xfer(0, 12'(4 * i), 0);
            check(rdat, 32'h0);
            check(rerr, 1'b0);
        end
        xfer(1, 12'h014, 32'hff);
        check(rerr, 1'b1);
        xfer(0, 12'h014, 32'h0);
        check(rdat, 32'h0);
        check(rerr, 1'b1);
        xfer(1, `TMW_ADDR_COUNTER, 32'ha5);
        xfer(1, `TMW_ADDR_COMPARE, 32'h3c);
        pstrb <= 4'h0;
        xfer(1, `TMW_ADDR_COMPARE, 32'h11);
        pstrb <= 4'hf;
        xfer(0, `TMW_ADDR_COUNTER, 0);
        check(rdat, 32'ha5);
        xfer(0, `TMW_ADDR_COMPARE, 0);
        check(rdat, 32'h3c);
        xfer(1, `TMW_ADDR_CONTROL, 32'h10);
        repeat (3) @(posedge clk);
        check({ovr, oe}, 2'b10);
    endtask
    // Forced matches in both non-PWM modes, then refused in fast PWM
    task t_force;
        logic [1:0] coms [4] = '{2'h3, 2'h1, 2'h1, 2'h2};
        logic exps [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        xfer(1, `TMW_ADDR_PIN_DIR, 32'h1);
        xfer(1, `TMW_ADDR_COUNTER, 32'h5);
        xfer(1, `TMW_ADDR_COMPARE, 32'h5);
        xfer(1, `TMW_ADDR_FLAGS, 32'h3);
        for (int i = 0; i < 4; i++) begin
            xfer(1, `TMW_ADDR_CONTROL, {24'h0, 2'b10, coms[i], i[0], 3'h0});
            repeat (3) @(posedge clk);
            check(pin, exps[i]);
            check({ovr, oe}, 2'b11);
            xfer(0, `TMW_ADDR_CONTROL, 0);
            check(rdat, {24'h0, 2'b00, coms[i], i[0], 3'h0});
        end
        xfer(0, `TMW_ADDR_FLAGS, 0);
        check(rdat, 32'h0);
        xfer(0, `TMW_ADDR_COUNTER, 0);
        check(rdat, 32'h5);
        xfer(1, `TMW_ADDR_CONTROL, 32'hf8);
        repeat (3) @(posedge clk);
        check(pin, 1'b0);
    endtask
    task t_ctc;
        logic [7:0] mx;
        int n;
        mx = 0;
        n = 0;
        xfer(1, `TMW_ADDR_CONTROL, 32'h08);
        xfer(1, `TMW_ADDR_COUNTER, 32'h0);
        xfer(1, `TMW_ADDR_COMPARE, 32'h9);
        xfer(1, `TMW_ADDR_FLAGS, 32'h3);
        xfer(1, `TMW_ADDR_CONTROL, 32'h09);
        repeat (30) begin
            xfer(0, `TMW_ADDR_COUNTER, 0);
            if (rdat[7:0] > mx) mx = rdat[7:0];
        end
        check(mx, 8'h9);
        xfer(0, `TMW_ADDR_FLAGS, 0);
        check(rdat, 32'h2);
        xfer(1, `TMW_ADDR_COUNTER, 32'h14);
        xfer(1, `TMW_ADDR_FLAGS, 32'h3);
        do begin
            xfer(0, `TMW_ADDR_COUNTER, 0);
            n++;
        end while (rdat[7:0] >= 8'h14 && n < 200);
        if (rdat[7:0] >= 8'h14) begin
            errors++;
            end_of_test();
        end
        xfer(0, `TMW_ADDR_FLAGS, 0);
        check(rdat[0], 1'b1);
        xfer(1, `TMW_ADDR_COMPARE, 32'h5);
        xfer(1, `TMW_ADDR_COUNTER, 32'h5);
        xfer(0, `TMW_ADDR_COUNTER, 0);
        check(rdat[7:0] > 8'h5, 1'b1);
    endtask
    // Eight timer ticks for every divisor, then the stopped counter holds
    task t_prescale;
        for (int i = 0; i < 7; i++) begin
            xfer(1, `TMW_ADDR_CONTROL, 32'h0);
            xfer(1, `TMW_ADDR_COUNTER, 32'h0);
            xfer(1, `TMW_ADDR_CONTROL, 32'(i + 1));
            repeat (divs[i] * 8 - 3) @(posedge clk);
            xfer(1, `TMW_ADDR_CONTROL, 32'h0);
            xfer(0, `TMW_ADDR_COUNTER, 0);
            check(rdat >= 7 && rdat <= 9, 1'b1);
        end
        repeat (50) @(posedge clk);
        xfer(0, `TMW_ADDR_COUNTER, 0);
        check(rdat >= 7 && rdat <= 9, 1'b1);
    endtask
    task duty(input logic [7:0] ctl, input logic [7:0] cmp, input int lo, input int hi);
        int h;
        h = 0;
        xfer(1, `TMW_ADDR_CONTROL, 32'h0);
        xfer(1, `TMW_ADDR_COMPARE, {24'h0, cmp});
        xfer(1, `TMW_ADDR_CONTROL, {24'h0, ctl});
        repeat (600) @(posedge clk);
        repeat (1020) begin
            @(posedge clk);
            if (pin === 1'b1) h++;
        end
        check(h >= lo && h <= hi, 1'b1);
        check({ovr, oe}, 2'b11);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_force();
        t_ctc();
        t_prescale();
        duty(8'h69, 8'h40, 250, 270);
        duty(8'h79, 8'h40, 750, 772);
        duty(8'h61, 8'h40, 240, 272);
        duty(8'h71, 8'h40, 748, 780);
        duty(8'h69, 8'hff, 1020, 1020);
        end_of_test();
    end
endmodule
